// ---- rtl/scm_pkg.sv ----
// Package: register map, field layout, reset values and modes of the clock control
package scm_pkg;
    // Register offsets (plain port address)
    localparam logic [1:0] ADDR_SCLK_SEL = 2'h0;
    localparam logic [1:0] ADDR_FOSC_CTL = 2'h1;
    localparam logic [1:0] ADDR_IRQ_STAT = 2'h2;
    localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;
    // Field positions
    localparam int SEL_MSB    = 7;
    localparam int SEL_LSB    = 5;
    localparam int HS_IDLE_B  = 1;
    localparam int LS_IDLE_B  = 0;
    localparam int HS_STAB_B  = 1;
    localparam int HS_EN_B    = 0;
    // Reset values
    localparam logic [2:0] SEL_RST   = 3'h0;
    localparam logic       HS_EN_RST = 1'b1;
    // Clock select codes
    localparam logic [2:0] SEL_SUB      = 3'h7;
    localparam int         DIV_STAGES   = 6;
    // Interrupt status bits
    localparam int IRQ_W        = 3;
    localparam int IRQ_HS_STAB  = 0;
    localparam int IRQ_LS_STAB  = 1;
    localparam int IRQ_SW_DONE  = 2;
    // Oscillator start-up times in ns
    localparam int HS_START_NS = 16000;
    localparam int LS_START_NS = 1000;
    localparam int CLK_NS      = 5;
    localparam int HS_START_CYC = (HS_START_NS + CLK_NS - 1) / CLK_NS;
    localparam int LS_START_CYC = (LS_START_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [2:0] {
        SCM_FAST    = 3'h0,
        SCM_SLOW    = 3'h1,
        SCM_IDLE_LO = 3'h3,
        SCM_IDLE_BO = 3'h2,
        SCM_IDLE_HI = 3'h6,
        SCM_SLEEP   = 3'h4
    } scm_mode_t;
endpackage

// ---- rtl/scm_stab_timer.sv ----
// Oscillator start-up timer: stable flag after a run of enabled cycles
module scm_stab_timer #(
    parameter int CYCLES = 4
) (
    input  wire logic clk_i,     // System clock
    input  wire logic rst_n_i,   // Synchronous reset, active low
    input  wire logic enable_i,  // Oscillator enabled
    output logic      stable_o   // Oscillator settled
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] count;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !enable_i) begin
            count    <= '0;
            stable_o <= 1'b0;
        end else if (!stable_o) begin
            count    <= count + CW'(1);
            stable_o <= (count == LAST);
        end
    end
endmodule

// ---- rtl/scm_divider.sv ----
// Divide-by-2^n pulse generator for the high-speed clock
module scm_divider #(
    parameter int STAGES = 6
) (
    input  wire logic             clk_i,    // System clock
    input  wire logic             rst_n_i,  // Synchronous reset, active low
    input  wire logic             run_i,    // Source running
    input  wire logic [2:0]       ratio_i,  // Log2 of divide ratio
    output logic                  tick_o    // One-cycle enable pulse
);
    logic [STAGES-1:0] count;
    wire  [STAGES-1:0] mask = STAGES'((1 << ratio_i) - 1);
    wire               hit  = ((count & mask) == '0);

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || !run_i) begin
            count  <= '0;
            tick_o <= 1'b0;
        end else begin
            count  <= count + STAGES'(1);
            tick_o <= hit;
        end
    end
endmodule

// ---- rtl/scm_top.sv ----
// System clock select, oscillator enables and halt mode control
// Function
// [RL1] sysclk_sel codes 0..6 pick high-speed clock / 1..64, code 7 sub clock.
// [RL2] High-speed clock from fast RC oscillator, sub clock from slow RC.
// [RL3] Moving to sub clock, fast oscillator runs or stops per hs_osc_en.
// [RL4] FAST mode: CPU runs on fast oscillator divided by sysclk_sel ratio.
// [RL5] SLOW mode: CPU on sub clock; fast clock follows hs_osc_en.
// [RL6] Halt with both idle bits 0 is SLEEP; slow osc only if watchdog.
// [RL7] Halt with hs 0, ls 1: CPU and fast clock off, sub clock on.
// [RL8] Halt with both idle bits 1: both oscillators stay on.
// [RL9] Halt with hs 1, ls 0: sub clock off, fast oscillator stays on.
// [RL10] hs_osc_idle_en is bit 1, resets to 0.
// [RL11] ls_osc_idle_en is bit 0, resets to 0.
// [RL12] Select register: sel bits 7..5, idle bits 1..0, bits 4..2 read 0.
// [RL13] hs_osc_stable bit 1 clears on enable, sets once oscillator settles.
// [RL14] hs_osc_en bit 0 enables fast oscillator, resets to 1.
// [RL15] Oscillator control bits 7..2 read as zero.
// [RL16] Software polls hs_osc_stable before trusting the fast clock.
// [RL17] Switch to SLOW mode waits for slow oscillator to be stable.
// [RL18] In standby, system clock runs only if its source is kept running.
module scm_top (
    input  wire logic       clk_i,        // System clock, 200 MHz
    input  wire logic       rst_n_i,      // Synchronous reset, active low
    input  wire logic [1:0] addr_i,       // Register address
    input  wire logic [7:0] wdata_i,      // Write data
    input  wire logic       wr_i,         // Write strobe
    input  wire logic       rd_i,         // Read strobe
    output logic [7:0]      rdata_o,      // Read data, cycle after strobe
    input  wire logic       halt_i,       // CPU executes halt, pulse
    input  wire logic       wake_i,       // Wake-up event, pulse
    input  wire logic       wdt_en_i,     // Watchdog enabled, async level
    output logic            cpu_run_o,    // CPU clock running
    output logic            sys_tick_o,   // System clock enable pulse
    output logic            sys_on_o,     // System clock not gated
    output logic            fast_osc_on_o,// Fast RC oscillator enable
    output logic            slow_osc_on_o,// Slow RC oscillator enable
    output logic            hs_clk_on_o,  // High-speed clock to peripherals
    output logic            sub_clk_on_o, // Sub clock to peripherals
    output logic            sub_src_o,    // System clock on sub source
    output logic [2:0]      mode_o,       // Operating mode code
    output logic            irq_o         // Level interrupt
);
    function automatic int pkg_w();
        return scm_pkg::IRQ_W;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2:0]            sysclk_sel;
    logic                  hs_osc_idle_en;
    logic                  ls_osc_idle_en;
    logic                  hs_osc_en;
    logic [pkg_w()-1:0]    irq_stat;
    logic [pkg_w()-1:0]    irq_mask;
    scm_pkg::scm_mode_t    mode;
    scm_pkg::scm_mode_t    next_mode;
    logic                  sub_src;
    logic                  wdt_meta;
    logic                  wdt_sync;
    logic                  hs_stable;
    logic                  ls_stable;
    logic                  hs_stable_q;
    logic                  ls_stable_q;
    logic                  div_tick;

    function automatic logic is_idle(input scm_pkg::scm_mode_t m);
        return m != scm_pkg::SCM_FAST && m != scm_pkg::SCM_SLOW;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire wr_sel  = wr_i && addr_i == scm_pkg::ADDR_SCLK_SEL;
    wire wr_osc  = wr_i && addr_i == scm_pkg::ADDR_FOSC_CTL;
    wire wr_mask = wr_i && addr_i == scm_pkg::ADDR_IRQ_MASK;
    wire rd_stat = rd_i && addr_i == scm_pkg::ADDR_IRQ_STAT;
    wire want_sub = (sysclk_sel == scm_pkg::SEL_SUB);                // RL1
    wire idle     = is_idle(mode);

    // Mode per halt idle bits
    wire scm_pkg::scm_mode_t halt_mode =
        !hs_osc_idle_en && !ls_osc_idle_en ? scm_pkg::SCM_SLEEP :    // RL6
        !hs_osc_idle_en                    ? scm_pkg::SCM_IDLE_LO :  // RL7
        ls_osc_idle_en                     ? scm_pkg::SCM_IDLE_BO :  // RL8
                                             scm_pkg::SCM_IDLE_HI;   // RL9

    // Oscillator requests per mode
    wire hs_req = idle ? (mode == scm_pkg::SCM_IDLE_BO ||
                          mode == scm_pkg::SCM_IDLE_HI)              // RL8 RL9
                       : (hs_osc_en || !sub_src);                    // RL3 RL5
    wire ls_req = (mode == scm_pkg::SCM_SLEEP) ? wdt_sync            // RL6
                : (mode == scm_pkg::SCM_IDLE_HI) ? 1'b0              // RL9
                : 1'b1;
    wire sub_on = ls_req && (mode != scm_pkg::SCM_SLEEP);            // RL6
    // Gate system clock in standby unless its source stays on
    wire sys_on = !idle || (sub_src ? sub_on : hs_req);              // RL18
    wire tick   = sub_src ? (sub_on && ls_stable)                    // RL2
                          : (div_tick && hs_stable);                 // RL4

    wire [7:0] sel_rd = {sysclk_sel, 3'h0,                           // RL12
                         hs_osc_idle_en, ls_osc_idle_en};
    wire [7:0] osc_rd = {6'h00, hs_stable, hs_osc_en};               // RL15
    wire sys_switch = want_sub ? ls_stable : hs_stable;              // RL17
    wire [pkg_w()-1:0] irq_ev = {
        sub_src != want_sub && sys_switch,
        ls_stable && !ls_stable_q,
        hs_stable && !hs_stable_q};
    logic [7:0] rdata_next;

    always_comb begin
        unique case (addr_i)
            scm_pkg::ADDR_SCLK_SEL: rdata_next = sel_rd;
            scm_pkg::ADDR_FOSC_CTL: rdata_next = osc_rd;
            scm_pkg::ADDR_IRQ_STAT: rdata_next = 8'(irq_stat);
            scm_pkg::ADDR_IRQ_MASK: rdata_next = 8'(irq_mask);
        endcase
    end

    always_comb begin
        next_mode = mode;
        if (idle && wake_i)
            next_mode = sub_src ? scm_pkg::SCM_SLOW : scm_pkg::SCM_FAST;
        else if (!idle && halt_i)
            next_mode = halt_mode;
        else if (!idle)
            next_mode = sub_src ? scm_pkg::SCM_SLOW : scm_pkg::SCM_FAST;
    end

    // ------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------
    scm_stab_timer #(.CYCLES(scm_pkg::HS_START_CYC)) u_hs_tmr (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .enable_i (hs_req),                                          // RL13
        .stable_o (hs_stable)
    );

    scm_stab_timer #(.CYCLES(scm_pkg::LS_START_CYC)) u_ls_tmr (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .enable_i (ls_req),
        .stable_o (ls_stable)
    );

    scm_divider #(.STAGES(scm_pkg::DIV_STAGES)) u_div (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .run_i    (hs_stable),
        .ratio_i  (sysclk_sel),                                      // RL1
        .tick_o   (div_tick)
    );

    // ------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        wdt_meta <= wdt_en_i;
        wdt_sync <= wdt_meta;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sysclk_sel     <= scm_pkg::SEL_RST;
            hs_osc_idle_en <= 1'b0;                                  // RL10
            ls_osc_idle_en <= 1'b0;                                  // RL11
        end else if (wr_sel) begin
            sysclk_sel     <= wdata_i[scm_pkg::SEL_MSB:scm_pkg::SEL_LSB];
            hs_osc_idle_en <= wdata_i[scm_pkg::HS_IDLE_B];           // RL10
            ls_osc_idle_en <= wdata_i[scm_pkg::LS_IDLE_B];           // RL11
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            hs_osc_en <= scm_pkg::HS_EN_RST;                         // RL14
        else if (wr_osc)
            hs_osc_en <= wdata_i[scm_pkg::HS_EN_B];                  // RL14
    end

    // Source change only once the target oscillator has settled
    always_ff @(posedge clk_i) begin
        if (!rst_n_i)
            sub_src <= 1'b0;
        else if (!idle && sys_switch)
            sub_src <= want_sub;                                     // RL17
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            mode        <= scm_pkg::SCM_FAST;
            hs_stable_q <= 1'b0;
            ls_stable_q <= 1'b0;
        end else begin
            mode        <= next_mode;
            hs_stable_q <= hs_stable;
            ls_stable_q <= ls_stable;
        end
    end

    // Events win over the clear-on-read
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            irq_stat <= '0;
            irq_mask <= '0;
        end else begin
            irq_stat <= (rd_stat ? '0 : irq_stat) | irq_ev;
            if (wr_mask)
                irq_mask <= wdata_i[pkg_w()-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_o       <= 8'h00;
            cpu_run_o     <= 1'b0;
            sys_tick_o    <= 1'b0;
            sys_on_o      <= 1'b0;
            fast_osc_on_o <= 1'b0;
            slow_osc_on_o <= 1'b0;
            hs_clk_on_o   <= 1'b0;
            sub_clk_on_o  <= 1'b0;
            sub_src_o     <= 1'b0;
            mode_o        <= 3'h0;
            irq_o         <= 1'b0;
        end else begin
            rdata_o       <= rd_i ? rdata_next : 8'h00;
            cpu_run_o     <= !is_idle(next_mode);
            sys_tick_o    <= tick && sys_on;                         // RL18
            sys_on_o      <= sys_on;
            fast_osc_on_o <= hs_req;                                 // RL2
            slow_osc_on_o <= ls_req;
            hs_clk_on_o   <= hs_req && hs_stable;
            sub_clk_on_o  <= sub_on && ls_stable;
            sub_src_o     <= sub_src;
            mode_o        <= mode;
            irq_o         <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_halt_sleep;
        !idle && halt_i && !hs_osc_idle_en && !ls_osc_idle_en;
    endsequence

    sequence s_halt_any;
        !idle && halt_i;
    endsequence

    property p_sleep_entry;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_halt_sleep |=> mode == scm_pkg::SCM_SLEEP && !hs_req;
    endproperty
    AST_SLEEP_ENTRY: assert property (p_sleep_entry) // RL6
        else $error("sleep not entered on halt");

    property p_cpu_stop;
        @(posedge clk_i) disable iff (!rst_n_i)
        s_halt_any |=> !cpu_run_o;
    endproperty
    AST_CPU_STOP: assert property (p_cpu_stop) // RL6 RL7 RL8 RL9
        else $error("cpu clock not stopped on halt");

    property p_idle_lo;
        @(posedge clk_i) disable iff (!rst_n_i)
        mode == scm_pkg::SCM_IDLE_LO |-> !hs_req && sub_on;
    endproperty
    AST_IDLE_LO: assert property (p_idle_lo) // RL7
        else $error("low standby clocks wrong");

    property p_idle_bo;
        @(posedge clk_i) disable iff (!rst_n_i)
        mode == scm_pkg::SCM_IDLE_BO |-> hs_req && ls_req;
    endproperty
    AST_IDLE_BO: assert property (p_idle_bo) // RL8
        else $error("both-clock standby wrong");

    property p_idle_hi;
        @(posedge clk_i) disable iff (!rst_n_i)
        mode == scm_pkg::SCM_IDLE_HI |-> hs_req && !sub_on;
    endproperty
    AST_IDLE_HI: assert property (p_idle_hi) // RL9
        else $error("high standby clocks wrong");

    property p_sleep_ls;
        @(posedge clk_i) disable iff (!rst_n_i)
        mode == scm_pkg::SCM_SLEEP |=> slow_osc_on_o == $past(wdt_sync);
    endproperty
    AST_SLEEP_LS: assert property (p_sleep_ls) // RL6
        else $error("slow osc in sleep not per watchdog");

    property p_sel_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == scm_pkg::ADDR_SCLK_SEL |=> rdata_o[4:2] == 3'h0;
    endproperty
    AST_SEL_ZERO: assert property (p_sel_zero) // RL12
        else $error("select reserved bits not zero");

    property p_osc_zero;
        @(posedge clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == scm_pkg::ADDR_FOSC_CTL
        |=> rdata_o[7:2] == 6'h00 && rdata_o[0] == $past(hs_osc_en);
    endproperty
    AST_OSC_ZERO: assert property (p_osc_zero) // RL15
        else $error("oscillator control read wrong");

    property p_stab_clr;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(hs_req) |=> !hs_stable;
    endproperty
    AST_STAB_CLR: assert property (p_stab_clr) // RL13
        else $error("stable flag not cleared on enable");

    property p_slow_wait;
        @(posedge clk_i) disable iff (!rst_n_i)
        $rose(sub_src) |-> $past(ls_stable);
    endproperty
    AST_SLOW_WAIT: assert property (p_slow_wait) // RL17
        else $error("sub switch before slow osc stable");

    property p_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
        idle && !sys_on |=> !sys_tick_o;
    endproperty
    AST_GATE: assert property (p_gate) // RL18
        else $error("system clock not gated in standby");

    property p_hs_keep;
        @(posedge clk_i) disable iff (!rst_n_i)
        !idle && sub_src && !hs_osc_en |-> !hs_req;
    endproperty
    AST_HS_KEEP: assert property (p_hs_keep) // RL3
        else $error("fast osc kept on when disabled");

    // Mode follows the source one cycle late, hence the look back
    property p_slow_src;
        @(posedge clk_i) disable iff (!rst_n_i)
        mode == scm_pkg::SCM_SLOW |-> $past(sub_src);
    endproperty
    AST_SLOW_SRC: assert property (p_slow_src) // RL5
        else $error("slow mode without sub source");

    property p_fast_src;
        @(posedge clk_i) disable iff (!rst_n_i)
        mode == scm_pkg::SCM_FAST |-> !$past(sub_src);
    endproperty
    AST_FAST_SRC: assert property (p_fast_src) // RL4
        else $error("fast mode on sub source");

    property p_sub_gate;
        @(posedge clk_i) disable iff (!rst_n_i)
        sub_src && !ls_stable |=> !sys_tick_o;
    endproperty
    AST_SUB_GATE: assert property (p_sub_gate) // RL2
        else $error("sub clock ticks before slow osc stable");
endmodule

// ---- dv/scm_cpu_model.sv ----
// CPU core and clock consumer model facing the clock control block
module scm_cpu_model (
    input  wire logic clk_i,      // System clock
    input  wire logic rst_n_i,    // Synchronous reset, active low
    input  wire logic halt_req_i, // Bench asks for a halt
    input  wire logic wake_req_i, // Bench asks for a wake-up
    input  wire logic clr_i,      // Clear the tick count
    input  wire logic tick_i,     // System clock enable
    input  wire logic run_i,      // CPU clock running
    output logic      halt_o,     // Halt instruction pulse
    output logic      wake_o,     // Wake event pulse
    output int        ticks_o     // System clock ticks seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // A halt is an instruction, so it can only issue while the CPU runs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            halt_o  <= 1'b0;
            wake_o  <= 1'b0;
            ticks_o <= 0;
        end else begin
            halt_o  <= halt_req_i & run_i & ~halt_o;
            wake_o  <= wake_req_i & ~run_i & ~wake_o;
            ticks_o <= clr_i ? 0 : ticks_o + (tick_i ? 1 : 0);
        end
    end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the system clock and mode control
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [1:0] A_SEL = scm_pkg::ADDR_SCLK_SEL;
    localparam logic [1:0] A_OSC = scm_pkg::ADDR_FOSC_CTL;
    localparam logic [1:0] A_STA = scm_pkg::ADDR_IRQ_STAT;
    localparam logic [1:0] A_MSK = scm_pkg::ADDR_IRQ_MASK;
    localparam int HS = scm_pkg::HS_START_CYC;
    localparam int LS = scm_pkg::LS_START_CYC;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic       wdt_en_i = 1'b0;
    logic       halt_req = 1'b0;
    logic       wake_req = 1'b0;
    logic       clr = 1'b0;
    logic       halt_i, wake_i, cpu_run_o, sys_tick_o, sys_on_o;
    logic       fast_osc_on_o, slow_osc_on_o, hs_clk_on_o, sub_clk_on_o;
    logic       sub_src_o, irq_o;
    logic [7:0] rdata_o, d;
    logic [2:0] mode_o;
    int         ticks, n;
    int         failures = 0;
    int         checked = 0;
    scm_pkg::scm_mode_t idle_mode [4] = '{scm_pkg::SCM_SLEEP,
        scm_pkg::SCM_IDLE_LO, scm_pkg::SCM_IDLE_HI, scm_pkg::SCM_IDLE_BO};

    always #2.5 clk_i = ~clk_i;

    scm_top uut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .halt_i, .wake_i, .wdt_en_i, .cpu_run_o, .sys_tick_o,
        .sys_on_o, .fast_osc_on_o, .slow_osc_on_o, .hs_clk_on_o,
        .sub_clk_on_o, .sub_src_o, .mode_o, .irq_o);
    scm_cpu_model cpu (.clk_i, .rst_n_i, .halt_req_i(halt_req),
        .wake_req_i(wake_req), .clr_i(clr), .tick_i(sys_tick_o),
        .run_i(cpu_run_o), .halt_o(halt_i), .wake_o(wake_i), .ticks_o(ticks));

    // ----------------------------------------
    // Compare and access tasks
    // ----------------------------------------
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi,
                           input int g);
        checked++;
        if (g < lo || g > hi) begin
            failures++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic pulse(input bit h);
        @(posedge clk_i);
        halt_req <= h;
        wake_req <= ~h;
        @(posedge clk_i);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? sub_src_o : cpu_run_o;
    endfunction
    task automatic wait_for(input int s, input logic v, input int lim);
        for (int i = 0; i < lim && pick(s) !== v; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk1("wait_level", v, pick(s));
    endtask
    // Software must see the fast oscillator settled before trusting it
    task automatic poll_stable();
        n = 0;
        do begin
            rd(A_OSC);
            n += 2;
        end while (d[scm_pkg::HS_STAB_B] !== 1'b1 && n < 4 * HS);
    endtask
    task automatic tally_and_finish();
        if (failures == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(A_SEL);
        chk8("sel_reset", 8'h00, d);
        rd(A_OSC);
        chk8("osc_reset", 8'h01, d & 8'hFD);
        rd(A_MSK);
        chk8("mask_reset", 8'h00, d);
        chk1("irq_reset", 1'b0, irq_o);
        poll_stable();
        chk1("hs_osc_reset", 1'b1, fast_osc_on_o);
        rd(A_STA);
        chk8("stab_event", 8'h01, d & 8'h01);
        wr(A_SEL, 8'hFF);
        rd(A_SEL);
        chk8("sel_rw", 8'hE3, d);
        wr(A_SEL, 8'hE0);
        wait_for(0, 1'b1, 4 * LS);
        cyc(2);
        chk8("mode_slow", {5'h00, scm_pkg::SCM_SLOW}, {5'h00, mode_o});
        chk1("hs_kept", 1'b1, hs_clk_on_o);
        wr(A_MSK, 8'h01);
        wr(A_OSC, 8'h00);
        cyc(4);
        chk1("hs_osc_off", 1'b0, fast_osc_on_o);
        chk1("hs_clk_off", 1'b0, hs_clk_on_o);
        chk1("slow_run", 1'b1, cpu_run_o);
        wr(A_OSC, 8'hFF);
        rd(A_OSC);
        chk8("stab_cleared", 8'h01, d);
        chk1("irq_wait", 1'b0, irq_o);
        poll_stable();
        chk_rng("stab_time", HS - 4, HS + 40, n);
        cyc(3);
        chk1("irq_set", 1'b1, irq_o);
        wr(A_MSK, 8'h00);
        cyc(3);
        chk1("irq_masked", 1'b0, irq_o);
        wr(A_MSK, 8'h01);
        cyc(3);
        chk1("irq_unmasked", 1'b1, irq_o);
        rd(A_STA);
        chk8("stat_read", 8'h01, d & 8'h01);
        cyc(3);
        chk1("irq_cleared", 1'b0, irq_o);
        rd(A_STA);
        chk8("stat_clear", 8'h00, d & 8'h01);
        for (int c = 0; c < 7; c++) begin
            wr(A_SEL, {c[2:0], 5'h00});
            wait_for(0, 1'b0, 4 * LS);
            rd(A_STA);
            chk8("switch_event", (c == 0) ? 8'h04 : 8'h00, d & 8'h04);
            cyc(8);
            @(posedge clk_i);
            clr <= 1'b1;
            @(posedge clk_i);
            clr <= 1'b0;
            cyc(512);
            #1;
            chk_rng("div_ticks", (512 >> c) - 1, (512 >> c) + 1, ticks);
            chk8("mode_fast", {5'h00, scm_pkg::SCM_FAST}, {5'h00, mode_o});
        end
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_i);
            wdt_en_i <= k[2];
            wr(A_SEL, {k[2] ? 3'h7 : 3'h0, 3'h0, k[1], k[0]});
            wait_for(0, k[2], 4 * LS);
            pulse(1'b1);
            cyc(6);
            #1;
            chk8("idle_mode", {5'h00, idle_mode[k[1:0]]}, {5'h00, mode_o});
            chk1("cpu_halted", 1'b0, cpu_run_o);
            chk1("hs_idle", k[1], hs_clk_on_o);
            chk1("sub_idle", k[0], sub_clk_on_o);
            chk1("sys_gate", k[2] ? k[0] : k[1], sys_on_o);
            if (k[1:0] == 2'b00) begin
                chk1("wdt_osc", k[2], slow_osc_on_o);
            end
            pulse(1'b0);
            wait_for(1, 1'b1, 4 * HS);
            poll_stable();
            cyc(LS);
        end
        tally_and_finish();
    end

    // A hang costs one mismatch and ends the run the same way
    initial begin
        cyc(80000);
        failures++;
        tally_and_finish();
    end
endmodule
